// *** core/lrc_map.svh ***
// Register offsets, field positions, reset values and timing counts of the loop control bank.
`ifndef LRC_MAP_SVH
`define LRC_MAP_SVH

`define LRC_ADDR_LOOP_CTRL 8'h1F
`define LRC_ADDR_OL_PERIOD 8'h20
`define LRC_ADDR_VBAT      8'h21
`define LRC_ADDR_RES       8'h22

`define LRC_RST_LOOP_CTRL  8'h80
`define LRC_RST_OL_PERIOD  8'h00
`define LRC_RST_VBAT       8'h00
`define LRC_RST_RES        8'h00

`define LRC_RETRY_MSB      7
`define LRC_RETRY_LSB      6
`define LRC_AUTO_FB_BIT    5
`define LRC_INTERVAL_BIT   4
`define LRC_BLANK_MSB      3
`define LRC_BLANK_LSB      2
`define LRC_IDISS_MSB      1
`define LRC_IDISS_LSB      0
`define LRC_RETRY_BASE     3

`define LRC_CLK_NS         20
`define LRC_TICK_NS        98460
`define LRC_TICK_CYCLES    ((`LRC_TICK_NS + `LRC_CLK_NS - 1) / `LRC_CLK_NS)
`define LRC_STEP_SLOW_US   5000
`define LRC_STEP_FAST_US   1000
`define LRC_STEP_SLOW_CYC  ((`LRC_STEP_SLOW_US * 1000) / `LRC_CLK_NS)
`define LRC_STEP_FAST_CYC  ((`LRC_STEP_FAST_US * 1000) / `LRC_CLK_NS)
`define LRC_PRESC_W        13
`define LRC_TMR_W          20
`define LRC_I2C_ADDR       7'h2C

`endif

// *** core/lrc_pkg.sv ***
// Types shared by the loop control bank modules.
`include "lrc_map.svh"
package lrc_pkg;
  typedef enum logic [3:0] {
    I_IDLE, I_ADDR, I_AADDR, I_WPTR, I_AACK, I_WDATA, I_RDATA, I_RACK, I_RNEXT
  } lrc_i2c_e;

  typedef struct packed {
    lrc_i2c_e                st;
    logic [3:0]              bit_cnt;
    logic [7:0]              shift;
    logic [7:0]              ptr;
    logic                    rw;
    logic                    sda_oe;
    logic [7:0]              ctrl;
    logic [7:0]              olp;
    logic [7:0]              vbat;
    logic [7:0]              res;
    logic [1:0]              scl_sy;
    logic [1:0]              sda_sy;
    logic [1:0]              zc_sy;
    logic                    scl_d;
    logic                    sda_d;
    logic                    zc_d;
    logic [`LRC_PRESC_W-1:0] presc;
    logic [7:0]              half_ticks;
    logic [7:0]              prev_half;
    logic                    phase;
    logic                    locked;
    logic                    fallback;
    logic [2:0]              miss;
  } lrc_state_s;

  typedef struct packed {
    logic [`LRC_TMR_W-1:0] cnt;
  } lrc_tmr_s;
endpackage : lrc_pkg

// *** core/lrc_timer_if.sv ***
// Reload timer handshake between the bank and its period timers.
`timescale 1ns/100ps
`default_nettype none
`include "lrc_map.svh"
interface lrc_timer_if;
  logic                  load;
  logic [`LRC_TMR_W-1:0] load_val;
  logic                  expired;
  modport timer (input load, input load_val, output expired);
  modport user  (output load, output load_val, input expired);
endinterface : lrc_timer_if
`default_nettype wire

// *** core/lrc_period_timer.sv ***
// Free running reload down counter used for drive half periods and playback steps.
`timescale 1ns/100ps
`default_nettype none
`include "lrc_map.svh"
module lrc_period_timer (
  input wire logic    core_clk,
  input wire logic    rst,
  lrc_timer_if.timer  tif
);
  import lrc_pkg::*;

  lrc_tmr_s r;
  lrc_tmr_s n;

  assign tif.expired = (r.cnt == '0) && !tif.load;

  always_comb begin
    n = r;
    if (tif.load || (r.cnt == '0)) begin
      n.cnt = tif.load_val;
    end else begin
      n.cnt = r.cnt - `LRC_TMR_W'(1);
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end
endmodule : lrc_period_timer
`default_nettype wire

// *** core/lrc_loop_ctrl.sv ***
// Loop control and monitor register bank with I2C access and resonant drive sequencing.
// ---------------------------------------------------------------
// Overview of operation
// ---------------------------------------------------------------
// Overview of operation
// R1 - Retry field bits 7:6 give 3 to 6 sync attempts; reset code 2.
// R2 - Bit 5 set allows automatic fallback to open loop; clear never does.
// R3 - Bit 4 picks playback step: 0 is 5 ms, 1 is 1 ms.
// R4 - Bits 3:2 are upper blanking window bits, joined with external lower bits.
// R5 - Bits 1:0 are upper dissipation window bits, joined with external lower bits.
// R6 - Open loop drive period is register value times 98.46 us.
// R7 - Supply reading is an 8-bit code, volts equal code times 5.6/255.
// R8 - Supply reading updates only while a waveform is actively driven; the code also takes host I2C writes to it at any time.
// R9 - During drive, resonance period reported in 98.46 us units.
// R10 - Drive locks to resonance within half a cycle after starting.
// R11 - Back-EMF watched continuously; drive retimed every cycle to follow resonance.
// R12 - Resonance tracking needs no calibration and ignores level calibration.
// R13 - Open loop frequency in all playback modes comes from the period register.
// R14 - Loop mode bit: 0 auto-resonance, 1 open loop; not in analog mode.
// R15 - Readings hold their last value until the next drive measurement; the code also lets host I2C writes replace them.
`timescale 1ns/100ps
`default_nettype none
`include "lrc_map.svh"
module lrc_loop_ctrl #(
  parameter logic [6:0] DEV_ADDR         = `LRC_I2C_ADDR,
  parameter int         TICK_CYCLES      = `LRC_TICK_CYCLES,
  parameter int         STEP_SLOW_CYCLES = `LRC_STEP_SLOW_CYC,
  parameter int         STEP_FAST_CYCLES = `LRC_STEP_FAST_CYC
) (
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic       i2c_scl,
  input  wire logic       i2c_sda_in,
  output logic            i2c_sda_out,
  output logic            i2c_sda_oe,
  input  wire logic       drive_active,
  input  wire logic       lra_mode,
  input  wire logic       loop_mode_open,
  input  wire logic       analog_mode,
  input  wire logic       bemf_zc,
  input  wire logic [7:0] vbat_code,
  input  wire logic       vbat_valid,
  input  wire logic [1:0] blank_lo,
  input  wire logic [1:0] idiss_lo,
  output logic      [3:0] sense_blank_window,
  output logic      [3:0] current_dissipate_window,
  output logic            drive_phase,
  output logic            open_loop_active,
  output logic            res_locked,
  output logic            playback_step
);
  import lrc_pkg::*;

  lrc_state_s            r;
  lrc_state_s            n;
  lrc_timer_if           drv_tif ();
  lrc_timer_if           step_tif ();
  logic                  scl_s;
  logic                  sda_s;
  logic                  scl_rise;
  logic                  scl_fall;
  logic                  i2c_start;
  logic                  i2c_stop;
  logic                  zc_evt;
  logic                  wr_en;
  logic [7:0]            rd_data;
  logic [2:0]            attempts;
  logic                  auto_en;
  logic [19:0]           half_prod;
  logic [8:0]            per_sum;
  logic [7:0]            per_sat;

  // ---------------------------------------------------------------
  // Pin edges and decoded fields.
  // ---------------------------------------------------------------
  assign scl_s     = r.scl_sy[1];
  assign sda_s     = r.sda_sy[1];
  assign scl_rise  = scl_s && !r.scl_d;
  assign scl_fall  = !scl_s && r.scl_d;
  assign i2c_start = scl_s && r.scl_d && r.sda_d && !sda_s;
  assign i2c_stop  = scl_s && r.scl_d && !r.sda_d && sda_s;
  assign zc_evt    = r.zc_sy[1] && !r.zc_d;
  assign auto_en   = r.ctrl[`LRC_AUTO_FB_BIT];
  assign attempts  = 3'(`LRC_RETRY_BASE) + {1'b0, r.ctrl[`LRC_RETRY_MSB:`LRC_RETRY_LSB]}; // [R1]
  assign half_prod = 20'(({12'h000, r.olp} * TICK_CYCLES) >> 1); // [R6] [R13]
  assign per_sum   = {1'b0, r.prev_half} + {1'b0, r.half_ticks};
  assign per_sat   = per_sum[8] ? 8'hFF : per_sum[7:0];

  assign rd_data = (r.ptr == `LRC_ADDR_LOOP_CTRL) ? r.ctrl :
                   (r.ptr == `LRC_ADDR_OL_PERIOD) ? r.olp  :
                   (r.ptr == `LRC_ADDR_VBAT)      ? r.vbat :
                   (r.ptr == `LRC_ADDR_RES)       ? r.res  : 8'h00;

  // ---------------------------------------------------------------
  // Drive half period and playback step timers.
  // ---------------------------------------------------------------
  assign drv_tif.load     = !drive_active || (zc_evt && !open_loop_active);
  assign drv_tif.load_val = (half_prod == 20'h0_0000) ? 20'h0_0000 : half_prod - 20'h0_0001;
  assign step_tif.load    = !drive_active;
  assign step_tif.load_val = r.ctrl[`LRC_INTERVAL_BIT] ?
                             20'(STEP_FAST_CYCLES - 1) : 20'(STEP_SLOW_CYCLES - 1); // [R3]

  lrc_period_timer u_drv_tmr (
    .core_clk (core_clk),
    .rst      (rst),
    .tif      (drv_tif)
  );

  lrc_period_timer u_step_tmr (
    .core_clk (core_clk),
    .rst      (rst),
    .tif      (step_tif)
  );

  // ---------------------------------------------------------------
  // Outputs.
  // ---------------------------------------------------------------
  assign i2c_sda_out   = 1'b0;
  assign i2c_sda_oe    = r.sda_oe;
  assign sense_blank_window =
    {r.ctrl[`LRC_BLANK_MSB:`LRC_BLANK_LSB], blank_lo}; // [R4]
  assign current_dissipate_window =
    {r.ctrl[`LRC_IDISS_MSB:`LRC_IDISS_LSB], idiss_lo}; // [R5]
  assign open_loop_active = drive_active && lra_mode && !analog_mode &&
                            (loop_mode_open || r.fallback); // [R14] [R2]
  assign drive_phase   = r.phase;
  assign res_locked    = r.locked;
  assign playback_step = step_tif.expired && drive_active;

  // ---------------------------------------------------------------
  // Next state.
  // ---------------------------------------------------------------
  always_comb begin
    n = r;
    wr_en = 1'b0;
    n.scl_sy = {r.scl_sy[0], i2c_scl};
    n.sda_sy = {r.sda_sy[0], i2c_sda_in};
    n.zc_sy  = {r.zc_sy[0], bemf_zc};
    n.scl_d  = r.scl_sy[1];
    n.sda_d  = r.sda_sy[1];
    n.zc_d   = r.zc_sy[1];
    if (i2c_start) begin
      n.st = I_ADDR;
      n.bit_cnt = 4'h0;
      n.sda_oe = 1'b0;
    end else if (i2c_stop) begin
      n.st = I_IDLE;
      n.sda_oe = 1'b0;
    end else if (scl_rise) begin
      case (r.st)
        I_ADDR, I_WPTR, I_WDATA: begin
          n.shift = {r.shift[6:0], sda_s};
          n.bit_cnt = r.bit_cnt + 4'h1;
        end
        I_RACK:  n.st = sda_s ? I_IDLE : I_RNEXT;
        default: ;
      endcase
    end else if (scl_fall) begin
      case (r.st)
        I_ADDR: if (r.bit_cnt == 4'h8) begin
          if (r.shift[7:1] == DEV_ADDR) begin
            n.st = I_AADDR;
            n.rw = r.shift[0];
            n.sda_oe = 1'b1;
          end else begin
            n.st = I_IDLE;
          end
        end
        I_WPTR: if (r.bit_cnt == 4'h8) begin
          n.ptr = r.shift;
          n.st = I_AACK;
          n.sda_oe = 1'b1;
        end
        I_WDATA: if (r.bit_cnt == 4'h8) begin
          wr_en = 1'b1;
          n.ptr = r.ptr + 8'h01;
          n.st = I_AACK;
          n.sda_oe = 1'b1;
        end
        I_AADDR, I_RNEXT: begin
          n.bit_cnt = 4'h0;
          if (r.rw) begin
            n.shift = rd_data;
            n.sda_oe = !rd_data[7];
            n.ptr = r.ptr + 8'h01;
            n.st = I_RDATA;
          end else begin
            n.sda_oe = 1'b0;
            n.st = I_WPTR;
          end
        end
        I_AACK: begin
          n.bit_cnt = 4'h0;
          n.sda_oe = 1'b0;
          n.st = I_WDATA;
        end
        I_RDATA: if (r.bit_cnt == 4'h7) begin
          n.sda_oe = 1'b0;
          n.st = I_RACK;
        end else begin
          n.shift = {r.shift[6:0], 1'b0};
          n.sda_oe = !r.shift[6];
          n.bit_cnt = r.bit_cnt + 4'h1;
        end
        default: ;
      endcase
    end
    if (wr_en) begin
      if (r.ptr == `LRC_ADDR_LOOP_CTRL) n.ctrl = r.shift;
      if (r.ptr == `LRC_ADDR_OL_PERIOD) n.olp  = r.shift;
      if (r.ptr == `LRC_ADDR_VBAT)      n.vbat = r.shift;
      if (r.ptr == `LRC_ADDR_RES)       n.res  = r.shift;
    end
    // Tracking uses only back-EMF timing, never calibration results. [R12]
    if (!drive_active) begin
      n.presc = '0;
      n.half_ticks = 8'h00;
      n.prev_half = 8'h00;
      n.phase = 1'b0;
      n.locked = 1'b0;
      n.fallback = 1'b0;
      n.miss = 3'h0;
    end else begin
      if (r.presc == `LRC_PRESC_W'(TICK_CYCLES - 1)) begin
        n.presc = '0;
        if (r.half_ticks != 8'hFF) n.half_ticks = r.half_ticks + 8'h01;
      end else begin
        n.presc = r.presc + `LRC_PRESC_W'(1);
      end
      if (zc_evt) begin
        n.res = per_sat; // [R9] [R15]
        n.prev_half = r.half_ticks;
        n.half_ticks = 8'h00;
        n.locked = 1'b1; // [R10]
        n.miss = 3'h0;
        if (!open_loop_active) n.phase = !r.phase; // [R11]
      end else if (drv_tif.expired) begin
        n.phase = !r.phase; // [R6]
        if (auto_en && lra_mode && !open_loop_active) begin
          n.miss = r.miss + 3'h1;
          if ((r.miss + 3'h1) >= attempts) n.fallback = 1'b1; // [R1] [R2]
        end
      end
    end
    if (drive_active && vbat_valid) n.vbat = vbat_code; // [R7] [R8] [R15]
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      r <= '0;
      r.ctrl <= `LRC_RST_LOOP_CTRL;
      r.olp  <= `LRC_RST_OL_PERIOD;
      r.vbat <= `LRC_RST_VBAT;
      r.res  <= `LRC_RST_RES;
      r.st   <= I_IDLE;
      r.scl_sy <= 2'h3;
      r.sda_sy <= 2'h3;
      r.scl_d <= 1'b1;
      r.sda_d <= 1'b1;
    end else begin
      r <= n;
    end
  end

  // ---------------------------------------------------------------
  // Checks.
  // ---------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence s_zc_driven;
    zc_evt && drive_active;
  endsequence
  sequence s_miss_limit;
    drv_tif.expired && !zc_evt && drive_active && auto_en && lra_mode &&
    !open_loop_active && ((r.miss + 3'h1) >= attempts);
  endsequence

  chk_retry_limit: assert property (s_miss_limit |=> r.fallback) // [R1]
    else $error("fallback not taken at retry limit");
  chk_fallback_gate: assert property ($rose(r.fallback) |-> $past(auto_en)) // [R2]
    else $error("fallback taken while disabled");
  chk_step_choice: assert property (playback_step && r.ctrl[`LRC_INTERVAL_BIT] // [R3]
    |=> u_step_tmr.r.cnt == 20'(STEP_FAST_CYCLES - 1))
    else $error("wrong playback step reload");
  chk_blank_join: assert property (wr_en && r.ptr == `LRC_ADDR_LOOP_CTRL
    |=> sense_blank_window[3:2] == $past(r.shift[3:2])) // [R4]
    else $error("blanking upper bits not joined");
  chk_idiss_join: assert property (wr_en && r.ptr == `LRC_ADDR_LOOP_CTRL
    |=> current_dissipate_window[3:2] == $past(r.shift[1:0])) // [R5]
    else $error("dissipation upper bits not joined");
  chk_ol_toggle: assert property (open_loop_active && drv_tif.expired && !zc_evt
    |=> drive_phase != $past(drive_phase)) // [R6]
    else $error("open loop phase did not toggle");
  chk_vbat_hold: assert property (!drive_active && !wr_en |=> $stable(r.vbat)) // [R8]
    else $error("supply reading changed while idle");
  chk_res_capture: assert property (s_zc_driven |=> r.res == $past(per_sat)) // [R9]
    else $error("resonance period not captured");
  chk_lock_half: assert property (s_zc_driven |=> res_locked) // [R10]
    else $error("drive not locked after first crossing");
  chk_track_cycle: assert property (s_zc_driven ##0 !open_loop_active
    |=> drive_phase != $past(drive_phase)) // [R11]
    else $error("drive not retimed on crossing");
  chk_analog_closed: assert property (analog_mode |-> !open_loop_active) // [R14]
    else $error("open loop active in analog mode");
endmodule : lrc_loop_ctrl
`default_nettype wire

// *** test/lrc_host_model.sv ***
// Behavioural I2C host that reads and writes the loop control bank registers.
`timescale 1ns/100ps
`default_nettype none
module lrc_host_model #(
  parameter logic [6:0] DEV_ADDR = 7'h2C
) (
  input  wire logic core_clk,
  input  wire logic sda,
  output var logic  scl,
  output var logic  pull_low
);
  initial begin
    scl = 1'b1;
    pull_low = 1'b0;
  end
  task automatic q(input int n);
    repeat (4 * n) @(negedge core_clk);
  endtask : q
  task automatic put_bit(input logic b);
    q(1);
    pull_low = !b;
    q(1);
    scl = 1'b1;
    q(2);
    scl = 1'b0;
  endtask : put_bit
  task automatic get_bit(output logic b);
    q(1);
    pull_low = 1'b0;
    q(1);
    scl = 1'b1;
    b = sda;
    q(2);
    scl = 1'b0;
  endtask : get_bit
  task automatic start();
    q(1);
    pull_low = 1'b0;
    q(1);
    scl = 1'b1;
    q(1);
    pull_low = 1'b1;
    q(1);
    scl = 1'b0;
  endtask : start
  task automatic stop();
    q(1);
    pull_low = 1'b1;
    q(1);
    scl = 1'b1;
    q(1);
    pull_low = 1'b0;
    q(2);
  endtask : stop
  task automatic send(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) put_bit(b[i]);
    get_bit(s);
    ack = !s;
  endtask : send
  task automatic wr(input logic [7:0] ptr, input logic [7:0] d);
    logic a;
    start();
    send({DEV_ADDR, 1'b0}, a);
    send(ptr, a);
    send(d, a);
    stop();
  endtask : wr
  task automatic rd(input logic [7:0] ptr, output logic [7:0] d);
    logic a;
    start();
    send({DEV_ADDR, 1'b0}, a);
    send(ptr, a);
    start();
    send({DEV_ADDR, 1'b1}, a);
    for (int i = 7; i >= 0; i--) get_bit(d[i]);
    put_bit(1'b1);
    stop();
  endtask : rd
  task automatic probe(input logic [6:0] adr, output logic ack);
    start();
    send({adr, 1'b0}, ack);
    stop();
  endtask : probe
endmodule : lrc_host_model
`default_nettype wire

// *** test/tb_top.sv ***
// Self-checking bench for the loop control bank, driven through the I2C host model.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic       core_clk = 1'b0;
  logic       rst = 1'b1;
  logic       scl, host_low, sda_out, sda_oe, sda;
  logic       drive_active = 1'b0, lra_mode = 1'b1, loop_mode_open = 1'b0, analog_mode = 1'b0;
  logic       bemf_zc = 1'b0, vbat_valid = 1'b0;
  logic [7:0] vbat_code = 8'h00;
  logic [1:0] blank_lo = 2'b11, idiss_lo = 2'b10;
  logic [3:0] blank_win, diss_win;
  logic       drive_phase, ol_active, res_locked, playback_step;
  int         n_mismatch = 0, total_checks = 0, cycles = 0;
  always #10 core_clk = !core_clk;
  assign sda = !(host_low || (sda_oe && !sda_out));
  lrc_host_model host (.core_clk(core_clk), .sda(sda), .scl(scl), .pull_low(host_low));
  lrc_loop_ctrl #(.TICK_CYCLES(4), .STEP_SLOW_CYCLES(40), .STEP_FAST_CYCLES(8)) dut (
    .core_clk(core_clk), .rst(rst), .i2c_scl(scl), .i2c_sda_in(sda),
    .i2c_sda_out(sda_out), .i2c_sda_oe(sda_oe), .drive_active(drive_active),
    .lra_mode(lra_mode), .loop_mode_open(loop_mode_open), .analog_mode(analog_mode),
    .bemf_zc(bemf_zc), .vbat_code(vbat_code), .vbat_valid(vbat_valid),
    .blank_lo(blank_lo), .idiss_lo(idiss_lo), .sense_blank_window(blank_win),
    .current_dissipate_window(diss_win), .drive_phase(drive_phase),
    .open_loop_active(ol_active), .res_locked(res_locked), .playback_step(playback_step));
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : wrap_up
  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask : cyc
  task automatic wait_lvl(ref logic sig, input logic lvl, output int n);
    n = 0;
    do begin
      cyc(1);
      n++;
    end while (sig !== lvl && n < 300);
  endtask : wait_lvl
  task automatic t_regs();
    logic [7:0] v;
    logic a;
    host.rd(8'h1F, v);
    check("ctrl reset", v, 8'h80);
    host.rd(8'h20, v);
    check("period reset", v, 8'h00);
    host.rd(8'h21, v);
    check("supply reset", v, 8'h00);
    host.rd(8'h22, v);
    check("resonance reset", v, 8'h00);
    check("blank reset", {4'h0, blank_win}, 8'h03);
    check("diss reset", {4'h0, diss_win}, 8'h02);
    host.wr(8'h1F, 8'hE9);
    host.rd(8'h1F, v);
    check("ctrl write", v, 8'hE9);
    check("blank win", {4'h0, blank_win}, 8'h0B);
    check("diss win", {4'h0, diss_win}, 8'h06);
    host.wr(8'h23, 8'h55);
    host.rd(8'h23, v);
    check("unmapped", v, 8'h00);
    host.probe(7'h2D, a);
    check("foreign ack", {7'h0, a}, 8'h00);
  endtask : t_regs
  task automatic t_step();
    int n;
    for (int i = 0; i < 2; i++) begin
      host.wr(8'h1F, (i == 1) ? 8'h90 : 8'h80);
      drive_active = 1'b1;
      wait_lvl(playback_step, 1'b1, n);
      wait_lvl(playback_step, 1'b1, n);
      check("step gap", n[7:0], (i == 1) ? 8'd8 : 8'd40);
      drive_active = 1'b0;
    end
  endtask : t_step
  task automatic strobe(input logic [7:0] c);
    vbat_code = c;
    vbat_valid = 1'b1;
    cyc(1);
    vbat_valid = 1'b0;
    cyc(2);
  endtask : strobe
  task automatic t_supply();
    logic [7:0] v;
    strobe(8'h5A);
    host.rd(8'h21, v);
    check("idle supply", v, 8'h00);
    drive_active = 1'b1;
    strobe(8'hA7);
    drive_active = 1'b0;
    strobe(8'h11);
    host.rd(8'h21, v);
    check("held supply", v, 8'hA7);
  endtask : t_supply
  task automatic zc(input int gap);
    cyc(gap - 1);
    bemf_zc = 1'b1;
    cyc(1);
    bemf_zc = 1'b0;
  endtask : zc
  task automatic t_res();
    logic [7:0] v;
    int n;
    drive_active = 1'b1;
    cyc(5);
    check("early lock", {7'h0, res_locked}, 8'h00);
    zc(20);
    wait_lvl(res_locked, 1'b1, n);
    check("lock delay", (n <= 6) ? 8'h01 : 8'h00, 8'h01);
    for (int i = 0; i < 4; i++) zc(40);
    for (int i = 0; i < 4; i++) zc(60);
    cyc(4);
    drive_active = 1'b0;
    host.rd(8'h22, v);
    check("resonance period", v, 8'h1E);
  endtask : t_res
  task automatic t_fallback();
    int n;
    int e;
    logic p;
    host.wr(8'h20, 8'h02);
    for (int c = 0; c < 4; c++) begin
      host.wr(8'h1F, 8'(c * 64 + 32));
      drive_active = 1'b1;
      e = (3 + c) * 4;
      wait_lvl(ol_active, 1'b1, n);
      check("fallback delay", (n >= e - 1 && n <= e + 3) ? 8'h01 : 8'h00, 8'h01);
      p = drive_phase;
      wait_lvl(drive_phase, !p, n);
      wait_lvl(drive_phase, p, n);
      check("open half period", n[7:0], 8'd4);
      drive_active = 1'b0;
      cyc(2);
    end
    host.wr(8'h1F, 8'hC0);
    drive_active = 1'b1;
    cyc(100);
    check("no fallback", {7'h0, ol_active}, 8'h00);
    loop_mode_open = 1'b1;
    cyc(2);
    check("open select", {7'h0, ol_active}, 8'h01);
    analog_mode = 1'b1;
    cyc(2);
    check("analog mode", {7'h0, ol_active}, 8'h00);
    drive_active = 1'b0;
  endtask : t_fallback
  task automatic t_reset();
    logic [7:0] v;
    host.wr(8'h20, 8'h5A);
    cyc(2);
    rst = 1'b1;
    cyc(3);
    rst = 1'b0;
    cyc(4);
    host.rd(8'h20, v);
    check("period after reset", v, 8'h00);
    host.rd(8'h1F, v);
    check("ctrl after reset", v, 8'h80);
    host.rd(8'h21, v);
    check("supply after reset", v, 8'h00);
    host.rd(8'h22, v);
    check("resonance after reset", v, 8'h00);
  endtask : t_reset
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 60000) begin
      n_mismatch++;
      wrap_up();
    end
  end
  initial begin
    cyc(3);
    rst = 1'b0;
    cyc(4);
    t_regs();
    t_step();
    t_supply();
    t_res();
    t_fallback();
    t_reset();
    wrap_up();
  end
endmodule : tb_top
`default_nettype wire
